// File: logic/usbft_pkg.sv
// package: offsets, field positions, reset values and carriers of the front-end test register
package usbft_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [11:0] TEST_CTRL_OFS  = 12'h0C4;
    localparam logic [31:0] RSVD_MASK      = 32'hFF87_000D;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int FS_OE_N_POS   = 22;
    localparam int FS_POS_POS    = 21;
    localparam int FS_NEG_POS    = 20;
    localparam int FS_RX_POS     = 19;
    localparam int VMASK_LSB     = 14;
    localparam int TXBITS_LSB    = 12;
    localparam int CS_ON_POS     = 11;
    localparam int TRIM_LSB      = 8;
    localparam int PU_POS_POS    = 7;
    localparam int PU_NEG_POS    = 6;
    localparam int PD_POS_POS    = 5;
    localparam int PD_NEG_POS    = 4;
    localparam int TX_ON_POS     = 1;

    // ****************************************************************
    // reset values and codes
    // ****************************************************************
    localparam logic [2:0]  TRIM_RST       = 3'h0;
    localparam logic [1:0]  VMASK_RST      = 2'h0;
    localparam logic [1:0]  VMASK_BAD      = 2'h2;
    localparam logic [1:0]  TXBITS_RST     = 2'h0;
    localparam logic [31:0] RDATA_RST      = 32'h0000_0000;
    localparam logic [1:0]  HRESP_OKAY     = 2'h0;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic       fs_driver_output_enable_n;
        logic       fs_positive_out_data;
        logic       fs_negative_out_data;
        logic [1:0] hs_tx_valid_mask;
        logic [1:0] hs_tx_bits;
        logic       hs_current_source_on;
        logic [2:0] hs_drive_current_trim;
        logic       pullup_pos_line_en;
        logic       pullup_neg_line_en;
        logic       pulldown_pos_line_en;
        logic       pulldown_neg_line_en;
        logic       hs_driver_transmit_on;
    } usbft_ctrl_s;

    localparam usbft_ctrl_s CTRL_RST = '{default: 1'b0};

endpackage

// File: logic/usbft_trim_src.sv
// trim default source: startup default, eeprom image and restore on usb or lite reset
`timescale 1ns/10ps
module usbft_trim_src (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // configuration sources
    input  wire logic       eeprom_present,
    input  wire logic       eeprom_load,
    input  wire logic [2:0] cfg_drive_current_trim,
    input  wire logic       otp_programmed,
    input  wire logic [2:0] otp_trim,
    // restoring resets
    input  wire logic       usb_reset,
    input  wire logic       lite_reset,
    // load request to the register
    output logic            trim_load,
    output logic [2:0]      trim_value
);

    typedef struct packed {
        logic       started;
        logic       eeprom_seen;
        logic [2:0] image;
        logic       load;
        logic [2:0] value;
    } usbft_src_s;

    usbft_src_s st_r;
    usbft_src_s st_nxt;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.load = 1'b0;
        if (!st_r.started) begin
            // strap caught in the first cycle after release
            st_nxt.started = 1'b1;
            st_nxt.eeprom_seen = eeprom_present;
            st_nxt.load = 1'b1;
            st_nxt.value = (!eeprom_present && otp_programmed) ? otp_trim : usbft_pkg::TRIM_RST;
        end else if (eeprom_load && st_r.eeprom_seen) begin
            st_nxt.image = cfg_drive_current_trim;
            st_nxt.load = 1'b1;
            st_nxt.value = cfg_drive_current_trim;
        end else if (usb_reset || lite_reset) begin
            st_nxt.load = 1'b1;
            st_nxt.value = st_r.eeprom_seen ? st_r.image : usbft_pkg::TRIM_RST;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '{default: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign trim_load  = st_r.load;
    assign trim_value = st_r.value;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_restore_image: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r.started && !eeprom_load && (usb_reset || lite_reset))
        |=> (trim_load && trim_value == (st_r.eeprom_seen ? $past(st_r.image) : 3'h0)))
        else $error("trim not restored after usb or lite reset");

endmodule // usbft_trim_src

// File: logic/usbft_test_reg.sv
// front-end test register: ahb-lite slave driving the usb 2.0 analog front end
//
// Function
// - test register is one 32-bit word at byte offset 0C4h.
// - bit 22 is active-low fs/ls driver enable, resets to 0.
// - bits 21 and 20 drive fs/ls data onto positive and negative lines.
// - read-only bit 19 shows the fs/ls differential receiver output.
// - bits 15:14 mark valid hs transmit bits; pattern 10 is invalid.
// - bits 13:12 hold two hs transmit bits, sent lsb first.
// - bit 11 powers hs current source; forced on in high-speed mode.
// - bits 10:8 trim hs drive current, 000 nominal.
// - protected resets leave the current trim unchanged.
// - trim default from eeprom, else otp, else 000.
// - usb or lite reset restores trim to eeprom image or 000.
// - bits 7 and 6 enable pull-ups on positive and negative lines.
// - bits 5 and 4 enable pull-downs on positive and negative lines.
// - bit 1 selects hs driver low-power idle or active transmit.
`timescale 1ns/10ps
module usbft_test_reg #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [1:0]             hresp,
    output logic [31:0]            hrdata,
    // front-end status and port mode
    input  wire logic              fs_receiver_out,
    input  wire logic              hs_mode,
    // resets acting on the register
    input  wire logic              usb_reset,
    input  wire logic              lite_reset,
    input  wire logic              soft_reset_protected,
    // trim configuration sources
    input  wire logic              eeprom_present,
    input  wire logic              eeprom_load,
    input  wire logic [2:0]        cfg_drive_current_trim,
    input  wire logic              otp_programmed,
    input  wire logic [2:0]        otp_trim,
    // analog front-end controls
    output usbft_pkg::usbft_ctrl_s afe_ctrl
);

    typedef struct packed {
        usbft_pkg::usbft_ctrl_s ctrl;
        logic                   cs_out;
        logic                   wr_pend;
        logic [31:0]            rdata;
    } usbft_state_s;

    usbft_state_s st_r;
    usbft_state_s st_nxt;

    logic       trim_load;
    logic [2:0] trim_value;
    logic       acc_hit;
    logic       rd_req;
    logic       wr_req;
    logic       rd_other;

    // ****************************************************************
    // trim default source
    // ****************************************************************
    usbft_trim_src u_trim_src (
        .hclk                   (hclk),
        .hresetn                (hresetn),
        .eeprom_present         (eeprom_present),
        .eeprom_load            (eeprom_load),
        .cfg_drive_current_trim (cfg_drive_current_trim),
        .otp_programmed         (otp_programmed),
        .otp_trim               (otp_trim),
        .usb_reset              (usb_reset),
        .lite_reset             (lite_reset),
        .trim_load              (trim_load),
        .trim_value             (trim_value)
    );

    // ****************************************************************
    // word packing
    // ****************************************************************
    function automatic logic [31:0] to_word(input usbft_pkg::usbft_ctrl_s c,
                                            input logic cs, input logic rx);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[usbft_pkg::FS_OE_N_POS] = c.fs_driver_output_enable_n;
        w[usbft_pkg::FS_POS_POS] = c.fs_positive_out_data;
        w[usbft_pkg::FS_NEG_POS] = c.fs_negative_out_data;
        w[usbft_pkg::FS_RX_POS] = rx;
        w[usbft_pkg::VMASK_LSB +: 2] = c.hs_tx_valid_mask;
        w[usbft_pkg::TXBITS_LSB +: 2] = c.hs_tx_bits;
        w[usbft_pkg::CS_ON_POS] = cs;
        w[usbft_pkg::TRIM_LSB +: 3] = c.hs_drive_current_trim;
        w[usbft_pkg::PU_POS_POS] = c.pullup_pos_line_en;
        w[usbft_pkg::PU_NEG_POS] = c.pullup_neg_line_en;
        w[usbft_pkg::PD_POS_POS] = c.pulldown_pos_line_en;
        w[usbft_pkg::PD_NEG_POS] = c.pulldown_neg_line_en;
        w[usbft_pkg::TX_ON_POS] = c.hs_driver_transmit_on;
        return w;
    endfunction

    // ****************************************************************
    // address phase decode
    // ****************************************************************
    assign acc_hit = hsel && hready && htrans[1]
                     && (haddr == ADDR_W'(usbft_pkg::TEST_CTRL_OFS));
    assign rd_req  = acc_hit && !hwrite;
    assign wr_req  = acc_hit && hwrite;
    assign rd_other = hsel && hready && htrans[1] && !hwrite && !acc_hit;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.wr_pend = wr_req;
        // protected reset clears all but the trim
        if (soft_reset_protected) begin
            st_nxt.ctrl = usbft_pkg::CTRL_RST;
            st_nxt.ctrl.hs_drive_current_trim = st_r.ctrl.hs_drive_current_trim;
        end
        // data phase of a write
        if (st_r.wr_pend) begin
            st_nxt.ctrl.fs_driver_output_enable_n = hwdata[usbft_pkg::FS_OE_N_POS];
            st_nxt.ctrl.fs_positive_out_data = hwdata[usbft_pkg::FS_POS_POS];
            st_nxt.ctrl.fs_negative_out_data = hwdata[usbft_pkg::FS_NEG_POS];
            if (hwdata[usbft_pkg::VMASK_LSB +: 2] != usbft_pkg::VMASK_BAD) begin
                st_nxt.ctrl.hs_tx_valid_mask = hwdata[usbft_pkg::VMASK_LSB +: 2];
            end
            st_nxt.ctrl.hs_tx_bits = hwdata[usbft_pkg::TXBITS_LSB +: 2];
            st_nxt.ctrl.hs_current_source_on = hwdata[usbft_pkg::CS_ON_POS];
            st_nxt.ctrl.hs_drive_current_trim = hwdata[usbft_pkg::TRIM_LSB +: 3];
            st_nxt.ctrl.pullup_pos_line_en = hwdata[usbft_pkg::PU_POS_POS];
            st_nxt.ctrl.pullup_neg_line_en = hwdata[usbft_pkg::PU_NEG_POS];
            st_nxt.ctrl.pulldown_pos_line_en = hwdata[usbft_pkg::PD_POS_POS];
            st_nxt.ctrl.pulldown_neg_line_en = hwdata[usbft_pkg::PD_NEG_POS];
            st_nxt.ctrl.hs_driver_transmit_on = hwdata[usbft_pkg::TX_ON_POS];
        end
        // default load and usb or lite reset win over software
        if (trim_load) begin
            st_nxt.ctrl.hs_drive_current_trim = trim_value;
        end
        // source powered by software, by high-speed mode or by active transmit
        st_nxt.cs_out = st_nxt.ctrl.hs_current_source_on || hs_mode
                        || st_nxt.ctrl.hs_driver_transmit_on;
        // read data sampled from the value as it will stand; other addresses read zero
        if (rd_req) begin
            st_nxt.rdata = to_word(st_nxt.ctrl, st_nxt.cs_out, fs_receiver_out);
        end else if (rd_other) begin
            st_nxt.rdata = usbft_pkg::RDATA_RST;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '{ctrl: usbft_pkg::CTRL_RST, cs_out: 1'b0, wr_pend: 1'b0,
                      rdata: usbft_pkg::RDATA_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign hreadyout = 1'b1;
    assign hresp     = usbft_pkg::HRESP_OKAY;
    assign hrdata    = st_r.rdata;

    always_comb begin
        afe_ctrl = st_r.ctrl;
        afe_ctrl.hs_current_source_on = st_r.cs_out;
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_wr_addr;
        hsel && hready && htrans[1] && hwrite && haddr == ADDR_W'(usbft_pkg::TEST_CTRL_OFS);
    endsequence

    sequence s_wr_data;
        s_wr_addr ##1 (!soft_reset_protected && !trim_load);
    endsequence

    sequence s_rd_addr;
        hsel && hready && htrans[1] && !hwrite && haddr == ADDR_W'(usbft_pkg::TEST_CTRL_OFS);
    endsequence

    sequence s_rd_other;
        hsel && hready && htrans[1] && !hwrite && haddr != ADDR_W'(usbft_pkg::TEST_CTRL_OFS);
    endsequence

    sequence s_wr_bad_mask;
        s_wr_data ##0 (hwdata[15:14] == 2'h2);
    endsequence

    sequence s_protect_only;
        soft_reset_protected && !st_r.wr_pend && !hs_mode;
    endsequence

    a_oe_write_lands: assert property (s_wr_data |=>
        afe_ctrl.fs_driver_output_enable_n == $past(hwdata[22])
        && afe_ctrl.fs_positive_out_data == $past(hwdata[21]))
        else $error("fs driver fields did not take written value");

    a_pull_write_lands: assert property (s_wr_data |=>
        afe_ctrl.pullup_neg_line_en == $past(hwdata[6])
        && afe_ctrl.pulldown_neg_line_en == $past(hwdata[4]))
        else $error("termination fields did not take written value");

    a_trim_write_lands: assert property (s_wr_data |=>
        afe_ctrl.hs_drive_current_trim == $past(hwdata[10:8]))
        else $error("trim did not take written value");

    a_mask_never_bad: assert property (
        afe_ctrl.hs_tx_valid_mask != 2'h2)
        else $error("invalid valid-mask pattern stored");

    a_rx_readback: assert property (s_rd_addr |=>
        hrdata[19] == $past(fs_receiver_out))
        else $error("receiver bit does not follow receiver");

    a_rsvd_read_zero: assert property (s_rd_addr |=>
        (hrdata & 32'hFF87_000D) == 32'h0000_0000)
        else $error("reserved bits read nonzero");

    a_cs_in_hs: assert property (hs_mode ##1 hs_mode |->
        afe_ctrl.hs_current_source_on)
        else $error("current source off in high-speed mode");

    a_tx_needs_cs: assert property (
        afe_ctrl.hs_driver_transmit_on |-> afe_ctrl.hs_current_source_on)
        else $error("transmit active without current source");

    a_trim_kept: assert property ((soft_reset_protected && !trim_load && !st_r.wr_pend) |=>
        afe_ctrl.hs_drive_current_trim == $past(afe_ctrl.hs_drive_current_trim)
        && !afe_ctrl.pullup_pos_line_en)
        else $error("protected reset disturbed trim or left fields set");

    a_trim_loaded: assert property (trim_load |=>
        afe_ctrl.hs_drive_current_trim == $past(trim_value))
        else $error("trim load not applied");

    a_neg_write_lands: assert property (s_wr_data |=>
        afe_ctrl.fs_negative_out_data == $past(hwdata[20]))
        else $error("negative line data did not take written value");

    a_bits_write_lands: assert property (s_wr_data |=>
        afe_ctrl.hs_tx_bits == $past(hwdata[13:12]))
        else $error("transmit bits did not take written value");

    a_pos_term_lands: assert property (s_wr_data |=>
        afe_ctrl.pulldown_pos_line_en == $past(hwdata[5])
        && afe_ctrl.pullup_pos_line_en == $past(hwdata[7]))
        else $error("positive line termination did not take written value");

    a_txon_write_lands: assert property (s_wr_data |=>
        afe_ctrl.hs_driver_transmit_on == $past(hwdata[1]))
        else $error("transmit mode did not take written value");

    a_cs_write_on: assert property (s_wr_data ##0 hwdata[11] |=>
        afe_ctrl.hs_current_source_on)
        else $error("current source off after being written on");

    a_cs_write_off: assert property (s_wr_data ##0 (!hwdata[11] && !hwdata[1] && !hs_mode) |=>
        !afe_ctrl.hs_current_source_on)
        else $error("current source on with nothing asking for it");

    a_mask_ok_lands: assert property (s_wr_data ##0 (hwdata[15:14] != 2'h2) |=>
        afe_ctrl.hs_tx_valid_mask == $past(hwdata[15:14]))
        else $error("valid mask did not take written value");

    a_mask_bad_kept: assert property (s_wr_bad_mask |=>
        afe_ctrl.hs_tx_valid_mask == $past(afe_ctrl.hs_tx_valid_mask))
        else $error("invalid valid-mask write changed the field");

    a_protect_clears: assert property (s_protect_only |=>
        {afe_ctrl.fs_driver_output_enable_n, afe_ctrl.hs_tx_valid_mask, afe_ctrl.hs_tx_bits,
         afe_ctrl.hs_current_source_on, afe_ctrl.pulldown_neg_line_en} == 7'h00)
        else $error("protected reset left fields set");

    a_other_read_zero: assert property (s_rd_other |=>
        hrdata == 32'h0000_0000)
        else $error("read of another address returned data");

    a_rdata_holds: assert property (!(hsel && hready && htrans[1] && !hwrite) |=>
        $stable(hrdata))
        else $error("read data changed without a read");

    a_bus_okay: assert property (hreadyout && hresp == 2'h0)
        else $error("slave not ready or not okay");

endmodule // usbft_test_reg

// File: dv/usbft_test_reg_tb.sv
// testbench: ahb-lite read and write checks of the front-end test register
`timescale 1ns/10ps
module usbft_test_reg_tb;

    // ****************************************************************
    // signals
    // ****************************************************************
    localparam logic [11:0] OFS = usbft_pkg::TEST_CTRL_OFS;
    logic                  hclk;
    logic                  hresetn;
    logic                  hsel;
    logic [11:0]           haddr;
    logic [1:0]            htrans;
    logic                  hwrite;
    logic [31:0]           hwdata;
    wire logic             hready;
    logic [1:0]            hresp;
    logic [31:0]           hrdata;
    logic                  fs_receiver_out;
    logic                  hs_mode;
    logic                  usb_reset;
    logic                  lite_reset;
    logic                  soft_reset_protected;
    logic                  eeprom_present;
    logic                  eeprom_load;
    logic [2:0]            cfg_drive_current_trim;
    logic                  otp_programmed;
    logic [2:0]            otp_trim;
    usbft_pkg::usbft_ctrl_s afe_ctrl;
    int                    failures;
    int                    check_count;
    logic [31:0]           rd_data;
    int                    bpos [12] = '{22, 21, 20, 14, 13, 12, 11, 7, 6, 5, 4, 1};
    int                    apos [12] = '{15, 14, 13, 11, 10, 9, 8, 4, 3, 2, 1, 0};

    usbft_test_reg #(.ADDR_W(12)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .fs_receiver_out(fs_receiver_out), .hs_mode(hs_mode), .usb_reset(usb_reset),
        .lite_reset(lite_reset), .soft_reset_protected(soft_reset_protected),
        .eeprom_present(eeprom_present), .eeprom_load(eeprom_load),
        .cfg_drive_current_trim(cfg_drive_current_trim), .otp_programmed(otp_programmed),
        .otp_trim(otp_trim), .afe_ctrl(afe_ctrl)
    );

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            failures++;
            $display("[FAIL] %0t bus wait timed out", $time);
            final_report();
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd_data = hrdata;
        check({30'h0, hresp}, {30'h0, usbft_pkg::HRESP_OKAY}, "response");
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, 32'h0);
        check(rd_data, exp, what);
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        tick(2);
        hresetn <= 1'b1;
        tick(3);
    endtask

    // ****************************************************************
    // sequence
    // ****************************************************************
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, fs_receiver_out, hs_mode, usb_reset, lite_reset} = 6'h00;
        {soft_reset_protected, eeprom_present, eeprom_load, otp_programmed} = 4'h0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwdata = 32'h0;
        cfg_drive_current_trim = 3'h0;
        otp_trim = 3'h0;
        failures = 0;
        check_count = 0;
        tick(2);
        hresetn <= 1'b1;
        tick(3);
        rd(OFS, 32'h0, "reset value");
        check({16'h0, afe_ctrl}, 32'h0, "afe reset");
        wr(OFS, 32'hFFFF_FFFF);
        rd(OFS, 32'h0070_FFF2, "all ones");
        check({16'h0, afe_ctrl}, 32'h0000_FFFF, "afe all ones");
        $display("test reset and reserved done");
        for (int i = 0; i < 12; i++) begin
            wr(OFS, 32'h1 << bpos[i]);
            rd(OFS, (32'h1 << bpos[i]) | ((bpos[i] == 1) ? 32'h800 : 32'h0), "bit");
            check({16'h0, afe_ctrl}, (32'h1 << apos[i]) | ((bpos[i] == 1) ? 32'h100 : 32'h0),
                  "afe bit");
        end
        $display("test single fields done");
        wr(OFS, 32'h0000_C000);
        wr(OFS, 32'h0000_8000);
        rd(OFS, 32'h0000_C000, "mask 10 kept");
        fs_receiver_out <= 1'b1;
        tick(1);
        rd(OFS, 32'h0008_C000, "receiver high");
        wr(OFS, 32'h0008_0000);
        rd(OFS, 32'h0008_0000, "receiver ro");
        fs_receiver_out <= 1'b0;
        wr(OFS, 32'h0);
        hs_mode <= 1'b1;
        tick(2);
        rd(OFS, 32'h0000_0800, "hs mode source");
        check({31'h0, afe_ctrl.hs_current_source_on}, 32'h1, "afe source");
        hs_mode <= 1'b0;
        tick(2);
        rd(OFS, 32'h0, "hs mode off");
        $display("test mask receiver source done");
        for (int i = 0; i < 8; i++) begin
            wr(OFS, 32'(i) << 8);
            rd(OFS, 32'(i) << 8, "trim code");
        end
        wr(12'h0C8, 32'hFFFF_FFFF);
        rd(12'h0C8, 32'h0, "unmapped");
        rd(12'h0C0, 32'h0, "unmapped low");
        rd(OFS, 32'h0000_0700, "unmapped write ignored");
        wr(OFS, 32'h0070_C5F2);
        soft_reset_protected <= 1'b1;
        tick(1);
        soft_reset_protected <= 1'b0;
        tick(1);
        rd(OFS, 32'h0000_0500, "protected trim");
        usb_reset <= 1'b1;
        tick(1);
        usb_reset <= 1'b0;
        tick(3);
        rd(OFS, 32'h0, "usb reset no eeprom");
        wr(OFS, 32'h0000_0300);
        lite_reset <= 1'b1;
        tick(1);
        lite_reset <= 1'b0;
        tick(3);
        rd(OFS, 32'h0, "lite reset no eeprom");
        $display("test trim and resets done");
        otp_programmed <= 1'b1;
        otp_trim <= 3'h5;
        do_reset();
        rd(OFS, 32'h0000_0500, "otp default");
        eeprom_present <= 1'b1;
        do_reset();
        cfg_drive_current_trim <= 3'h6;
        eeprom_load <= 1'b1;
        tick(1);
        eeprom_load <= 1'b0;
        tick(3);
        rd(OFS, 32'h0000_0600, "eeprom load");
        wr(OFS, 32'h0000_0300);
        lite_reset <= 1'b1;
        tick(1);
        lite_reset <= 1'b0;
        tick(3);
        rd(OFS, 32'h0000_0600, "lite restore");
        wr(OFS, 32'h0000_0100);
        usb_reset <= 1'b1;
        tick(1);
        usb_reset <= 1'b0;
        tick(3);
        rd(OFS, 32'h0000_0600, "usb restore");
        $display("test trim sources done");
        final_report();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        failures++;
        $display("[FAIL] %0t run timed out", $time);
        final_report();
    end

endmodule // usbft_test_reg_tb
